// [rtl/interval_timer.sv]
`timescale 1ns/10ps
`default_nettype none
// counts down a programmable number of cycles after a start pulse
module interval_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [31:0] period,
  output logic busy,
  output logic done
);
  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic busy_ff;
  logic done_ff;
  wire isLast = (count_ff == 32'h0000_0001);
  assign nxt_count = start ? period : (busy_ff ? count_ff - 32'h0000_0001 : count_ff);
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clkEn) begin
      count_ff <= nxt_count;
      busy_ff <= start | (busy_ff & ~isLast);
      done_ff <= busy_ff & isLast & ~start;
    end
  end
  assign busy = busy_ff;
  assign done = done_ff;
endmodule // interval_timer
`default_nettype wire

// [rtl/null_cmd_handler.sv]
// Notes on behaviour
// - power-up and any device clear leave the null feature off.
// - executing null_on shows zero and saves the value displayed before it.
// - in operate with null on, the load gets zero instead of the programmed value.
// - executing null_off shows the saved value again and sources it if in operate.
// - in voltage, current or charge a repeated null_on saves the present zero, losing the value.
// - a committed string takes effect and the block reports configured about 16 ms later.
// - when talking, one reading character goes out every 0.2 ms.
// - the reading is refreshed once per second, at most one new reading per second.
// - characters wait in the buffer until the commit character and run only if all were valid.
`timescale 1ns/10ps
`default_nettype none
module null_cmd_handler
  import null_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic devClear,
  input wire logic rxValid,
  input wire logic [7:0] rxChar,
  input wire logic [null_cmd_pkg::FUNC_W-1:0] funcSel,
  input wire logic operate,
  input wire logic [null_cmd_pkg::VALUE_W-1:0] programValue,
  input wire logic programLoad,
  input wire logic talkAddressed,
  input wire logic [7:0] readingChar,
  input wire logic readingLast,
  output logic readingTake,
  output logic txValid,
  output logic [7:0] txChar,
  output logic [null_cmd_pkg::VALUE_W-1:0] displayValue,
  output logic [null_cmd_pkg::VALUE_W-1:0] loadValue,
  output logic nullActive,
  output logic cmdError,
  output logic configured,
  output logic refreshTick
);
  import null_cmd_pkg::*;

  // ====================================================================
  // command parsing
  // ====================================================================
  parse_t state_ff;
  parse_t nxt_state;
  logic pendValid_ff;
  logic pendOn_ff;
  logic badString_ff;
  logic nullOn_ff;
  logic [VALUE_W-1:0] saved_ff;
  logic [VALUE_W-1:0] shown_ff;
  logic [VALUE_W-1:0] load_ff;
  logic cmdError_ff;
  logic execute;
  logic execGood;
  logic argChar;
  logic argOn;
  logic badChar;
  logic clearAll;

  assign clearAll = rst | devClear;
  assign argChar = (rxChar == CHAR_ZERO) | (rxChar == CHAR_ONE);
  assign argOn = (rxChar == CHAR_ONE);
  assign execute = rxValid & (rxChar == CHAR_EXEC);
  // string with a dangling null command counts as invalid
  assign execGood = execute & ~badString_ff & (state_ff != PS_NULL);
  assign badChar = rxValid & (state_ff == PS_NULL) & ~argChar;

  always_comb begin
    nxt_state = state_ff;
    if (execute) begin
      nxt_state = PS_IDLE;
    end else if (rxValid) begin
      case (state_ff)
        PS_NULL: nxt_state = argChar ? (argOn ? PS_ARG_ON : PS_ARG_OFF) : PS_IDLE;
        default: nxt_state = (rxChar == CHAR_NULL) ? PS_NULL : PS_IDLE;
      endcase
    end
  end

  // buffered, not acted on until commit; last null argument wins
  always_ff @(posedge clk) begin
    if (clearAll) begin
      state_ff <= PS_IDLE;
      pendValid_ff <= 1'b0;
      pendOn_ff <= 1'b0;
      badString_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      if (execute) begin
        pendValid_ff <= 1'b0;
        badString_ff <= 1'b0;
      end else begin
        if (rxValid & (state_ff == PS_NULL) & argChar) begin
          pendValid_ff <= 1'b1;
          pendOn_ff <= argOn;
        end
        if (badChar) begin
          badString_ff <= 1'b1;
        end
      end
    end
  end

  // ====================================================================
  // null state and saved value
  // ====================================================================
  logic doOn;
  logic doOff;
  logic repeatLoses;
  assign doOn = execGood & pendValid_ff & pendOn_ff;
  assign doOff = execGood & pendValid_ff & ~pendOn_ff;
  // in ohms a second null_on keeps the saved value; elsewhere it is lost
  assign repeatLoses = (funcSel == FUNC_VOLTS) | (funcSel == FUNC_AMPS) |
                       (funcSel == FUNC_COUL);

  always_ff @(posedge clk) begin
    if (clearAll) begin
      nullOn_ff <= 1'b0;
      saved_ff <= VALUE_ZERO;
      shown_ff <= VALUE_ZERO;
      cmdError_ff <= 1'b0;
    end else if (clkEn) begin
      if (execute) begin
        cmdError_ff <= ~execGood;
      end
      if (doOn) begin
        nullOn_ff <= 1'b1;
        shown_ff <= VALUE_ZERO;
        if (!nullOn_ff) begin
          saved_ff <= shown_ff;
        end else if (repeatLoses) begin
          saved_ff <= shown_ff;
        end
      end else if (doOff) begin
        nullOn_ff <= 1'b0;
        shown_ff <= saved_ff;
      end else if (programLoad) begin
        // a new value while null is on becomes the one to restore
        if (nullOn_ff) begin
          saved_ff <= programValue;
        end else begin
          shown_ff <= programValue;
        end
      end
    end
  end

  // zero sourced while null is on; standby sources nothing
  always_ff @(posedge clk) begin
    if (clearAll) begin
      load_ff <= VALUE_ZERO;
    end else if (clkEn) begin
      load_ff <= (operate & ~nullOn_ff) ? shown_ff : VALUE_ZERO;
    end
  end

  assign displayValue = shown_ff;
  assign loadValue = load_ff;
  assign nullActive = nullOn_ff;
  assign cmdError = cmdError_ff;

  // ====================================================================
  // timing: configure, character pacing, refresh
  // ====================================================================
  logic execBusy;
  logic execDone;
  logic charBusy;
  logic refreshDone;
  logic refreshBusy;
  logic configured_ff;
  logic readingReady_ff;
  logic sending_ff;
  logic txValid_ff;
  logic [7:0] txChar_ff;
  logic sendChar;

  interval_timer execTimer (
    .clk(clk),
    .rst(clearAll),
    .clkEn(clkEn),
    .start(execGood),
    .period(EXEC_CYCLES),
    .busy(execBusy),
    .done(execDone)
  );

  always_ff @(posedge clk) begin
    if (clearAll) begin
      configured_ff <= 1'b1;
    end else if (clkEn) begin
      configured_ff <= execDone | (configured_ff & ~execGood);
    end
  end
  assign configured = configured_ff & ~execBusy;

  // free-running one-second refresh
  interval_timer refreshTimer (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .start(~refreshBusy),
    .period(REFRESH_CYCLES),
    .busy(refreshBusy),
    .done(refreshDone)
  );
  assign refreshTick = refreshDone;

  assign sendChar = sending_ff & talkAddressed & ~charBusy;

  interval_timer charTimer (
    .clk(clk),
    .rst(clearAll),
    .clkEn(clkEn),
    .start(sendChar),
    .period(CHAR_CYCLES),
    .busy(charBusy),
    .done()
  );

  always_ff @(posedge clk) begin
    if (clearAll) begin
      readingReady_ff <= 1'b0;
      sending_ff <= 1'b0;
      txValid_ff <= 1'b0;
      txChar_ff <= 8'h00;
    end else if (clkEn) begin
      txValid_ff <= sendChar;
      if (sendChar) begin
        txChar_ff <= readingChar;
      end
      if (sendChar & readingLast) begin
        sending_ff <= 1'b0;
      end else if (readingReady_ff & ~sending_ff) begin
        sending_ff <= 1'b1;
      end
      // one reading armed per refresh, at most
      if (refreshDone) begin
        readingReady_ff <= 1'b1;
      end else if (readingReady_ff & ~sending_ff) begin
        readingReady_ff <= 1'b0;
      end
    end
  end
  assign readingTake = sendChar;
  assign txValid = txValid_ff;
  assign txChar = txChar_ff;
endmodule // null_cmd_handler
`default_nettype wire

// [rtl/null_cmd_pkg.sv]
`default_nettype none
package null_cmd_pkg;
  // command characters (ascii)
  localparam logic [7:0] CHAR_NULL = 8'h5A;
  localparam logic [7:0] CHAR_EXEC = 8'h58;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE = 8'h31;
  localparam int unsigned VALUE_W = 24;
  localparam int unsigned FUNC_W = 2;
  // function codes: voltage, current, charge, resistance
  localparam logic [1:0] FUNC_VOLTS = 2'h0;
  localparam logic [1:0] FUNC_AMPS = 2'h1;
  localparam logic [1:0] FUNC_COUL = 2'h2;
  localparam logic [1:0] FUNC_OHMS = 2'h3;
  localparam logic [23:0] VALUE_ZERO = 24'h00_0000;
  // timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned EXEC_TIME_US = 16000;
  localparam int unsigned CHAR_TIME_US = 200;
  localparam int unsigned REFRESH_TIME_US = 1000000;
  localparam int unsigned EXEC_CYCLES = EXEC_TIME_US * CLK_MHZ;
  localparam int unsigned CHAR_CYCLES = CHAR_TIME_US * CLK_MHZ;
  localparam int unsigned REFRESH_CYCLES = REFRESH_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  typedef enum logic [1:0] {PS_IDLE, PS_NULL, PS_ARG_OFF, PS_ARG_ON} parse_t;
endpackage
`default_nettype wire

// [verif/bus_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bus_ctrl_model
  import null_cmd_pkg::*;
(
  input wire logic clk,
  output logic rxValid,
  output logic [7:0] rxChar,
  output logic sentExec
);
  // real spacing is ~1 ms a char; shortened to keep the run brief
  localparam int GAP = 3;
  initial begin
    rxValid = 1'b0;
    rxChar = 8'h00;
    sentExec = 1'b0;
  end
  // ======
  // idle data inverted so a stale char never looks valid
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      #1;
      rxValid = 1'b1;
      rxChar = s[i];
      sentExec = s[i] == CHAR_EXEC;
      @(posedge clk);
      #1;
      rxValid = 1'b0;
      rxChar = ~rxChar;
      sentExec = 1'b0;
      repeat (GAP) @(posedge clk);
    end
  endtask
endmodule // bus_ctrl_model
`default_nettype wire

// [verif/null_cmd_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module null_cmd_sva
  import null_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic devClear,
  input wire logic rxValid,
  input wire logic [7:0] rxChar,
  input wire logic operate,
  input wire logic [null_cmd_pkg::VALUE_W-1:0] displayValue,
  input wire logic [null_cmd_pkg::VALUE_W-1:0] loadValue,
  input wire logic nullActive,
  input wire logic cmdError,
  input wire logic configured,
  input wire logic refreshTick
);
  logic xPrev_ff;
  wire logic xNow = rxValid && clkEn && rxChar == CHAR_EXEC;
  always_ff @(posedge clk) xPrev_ff <= xNow;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ======
  // assertions and covers
  a_rst_clear: assert property ($fell(rst) |-> !nullActive && configured
    && displayValue == VALUE_ZERO) else $error("reset state wrong");
  a_clear_off: assert property (devClear && clkEn |=> !nullActive)
    else $error("clear kept null");
  a_disp_zero: assert property (nullActive |-> displayValue == VALUE_ZERO)
    else $error("display not zero");
  a_load_zero: assert property (nullActive && $past(nullActive) && operate
    && $past(operate) |-> loadValue == VALUE_ZERO) else $error("load not zero");
  a_cfg_drop: assert property (xNow && !devClear |=> !configured || cmdError)
    else $error("configured high");
  // only a commit or a device clear may move the null state
  a_buf_hold: assert property (!xNow && !xPrev_ff && !devClear
    |=> $stable(nullActive)) else $error("null moved early");
  a_on_by_x: assert property ($rose(nullActive) |-> $past(xNow))
    else $error("null on without commit");
  a_tick_gap: assert property (refreshTick |=> !refreshTick [*8])
    else $error("ticks too close");
  c_null_on: cover property ($rose(nullActive));
  c_bad_str: cover property ($rose(cmdError));
  c_clear: cover property (devClear && nullActive);
endmodule // null_cmd_sva
`default_nettype wire

// [verif/output_null_command_handler_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module output_null_command_handler_tb;
  import null_cmd_pkg::*;
  logic clk, rst, devClear, rxValid, sentExec, operate, programLoad;
  logic take, txValid, nullAct, cmdErr, cfg, refTick;
  logic clkEn;
  logic talkSeen = 1'b0;
  logic [7:0] rxChar, txChar;
  logic [FUNC_W-1:0] func;
  logic [VALUE_W-1:0] progVal, dispVal, loadVal;
  logic [50:0] expQ[$];
  logic [2:0] dly = 3'h0;
  int errCount = 0;
  int checksDone = 0;
  int cycles = 0;
  int seed = 32'hdf93;
  null_cmd_handler dut (.clk(clk), .rst(rst), .clkEn(clkEn), .devClear(devClear),
    .rxValid(rxValid), .rxChar(rxChar), .funcSel(func), .operate(operate),
    .programValue(progVal), .programLoad(programLoad), .talkAddressed(1'b1),
    .readingChar(8'h41), .readingLast(1'b1), .readingTake(take), .txValid(txValid),
    .txChar(txChar), .displayValue(dispVal), .loadValue(loadVal), .nullActive(nullAct),
    .cmdError(cmdErr), .configured(cfg), .refreshTick(refTick));
  bus_ctrl_model ctl (.clk(clk), .rxValid(rxValid), .rxChar(rxChar), .sentExec(sentExec));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic stopTest();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmpState(input logic [50:0] exp, input logic [50:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cmd(input string s, input logic [50:0] e);
    expQ.push_back(e);
    ctl.send(s);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errCount++;
      stopTest();
    end
  end
  // ======
  // watcher: load settles one edge after the commit edge
  always @(posedge clk) begin
    dly <= {dly[1:0], sentExec};
    // no reading may leave before the first one-second refresh
    talkSeen <= talkSeen | txValid | take | refTick;
    if (dly[2]) begin
      cmpState(expQ.pop_front(), {nullAct, cmdErr, cfg, dispVal, loadVal});
    end
  end
  initial begin
    logic [VALUE_W-1:0] p;
    rst = 1'b1;
    clkEn = 1'b1;
    devClear = 1'b0;
    operate = 1'b1;
    programLoad = 1'b0;
    func = FUNC_VOLTS;
    progVal = 24'h00_0000;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    cmpState({3'b001, 48'h0}, {nullAct, cmdErr, cfg, dispVal, loadVal});
    for (int f = 0; f < 4; f++) begin
      p = 24'($random(seed));
      @(posedge clk);
      #1;
      func = f[1:0];
      progVal = p;
      programLoad = 1'b1;
      @(posedge clk);
      #1;
      programLoad = 1'b0;
      cmd("Z1X", {3'b100, 48'h0});
      cmd("Z0X", {3'b000, p, p});
      cmd("Z1X", {3'b100, 48'h0});
      cmd("Z1X", {3'b100, 48'h0});
      cmd("Z0X", (f == 3) ? {3'b000, p, p} : 51'h0);
    end
    cmd("Z7X", {3'b010, p, p});
    ctl.send("Z1");
    repeat (10) @(posedge clk);
    #1;
    cmpState(51'h0, {50'h0, nullAct});
    cmd("X", {3'b100, 48'h0});
    #1;
    devClear = 1'b1;
    @(posedge clk);
    #1;
    devClear = 1'b0;
    @(posedge clk);
    #1;
    cmpState(51'h0, {50'h0, nullAct});
    cmd("Z0X", 51'h0);
    // ======
    // frozen clock enable, then standby and back to operate
    p = 24'($random(seed));
    #1;
    clkEn = 1'b0;
    progVal = p;
    programLoad = 1'b1;
    @(posedge clk);
    #1;
    clkEn = 1'b1;
    programLoad = 1'b0;
    @(posedge clk);
    #1;
    cmpState(51'h0, {nullAct, cmdErr, cfg, dispVal, loadVal});
    operate = 1'b0;
    programLoad = 1'b1;
    @(posedge clk);
    #1;
    programLoad = 1'b0;
    @(posedge clk);
    #1;
    cmpState({3'b000, p, VALUE_ZERO}, {nullAct, cmdErr, cfg, dispVal, loadVal});
    operate = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmpState({3'b000, p, p}, {nullAct, cmdErr, cfg, dispVal, loadVal});
    repeat (10) @(posedge clk);
    #1;
    cmpState(51'h0, {42'h0, talkSeen, txChar});
    cmpState(51'h0, 51'(expQ.size()));
    stopTest();
  end
endmodule // output_null_command_handler_tb
bind null_cmd_handler null_cmd_sva chk (.clk(clk), .rst(rst), .clkEn(clkEn),
  .devClear(devClear), .rxValid(rxValid), .rxChar(rxChar), .operate(operate),
  .displayValue(displayValue), .loadValue(loadValue), .nullActive(nullActive),
  .cmdError(cmdError), .configured(configured), .refreshTick(refreshTick));
`default_nettype wire
